/* admission_guard.sv */
// Outstanding tracker and dependency check for one channel of one ingress.
// Assumes completions arrive only for transactions that were admitted.
`timescale 1ns/10ps
module admission_guard
#(
    parameter int IW = 2,
    parameter int DW = 2,
    parameter logic PER_ID = 1'b0
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [IW-1:0] req_id,
    input wire logic [DW-1:0] req_dest,
    input wire logic take,
    input wire logic done,
    input wire logic [IW-1:0] done_id,
    output logic pass,
    output logic busy
);
    import interconnect_admission_pkg::*;

    localparam int E = 1 << IW;

    logic [E-1:0][OST_W-1:0] cnt;
    logic [E-1:0][DW-1:0] dst;
    logic [E-1:0] inc;
    logic [E-1:0] dec;
    logic [IW-1:0] ri;
    logic [IW-1:0] di;

    // Single-destination mode folds every ID onto one entry
    assign ri = (PER_ID == CYCLIC_DEPENDENCY_AVOIDANCE_PER_ID) ? req_id : '0;
    assign di = (PER_ID == CYCLIC_DEPENDENCY_AVOIDANCE_PER_ID) ? done_id : '0;
    assign pass = (cnt[ri] == '0) || (dst[ri] == req_dest);
    assign busy = |cnt;

    always_comb
    begin
        for (int e = 0; e < E; e++)
        begin
            inc[e] = take && (ri == IW'(e));
            dec[e] = done && (di == IW'(e)) && (cnt[e] != '0);
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt <= '0;
            dst <= '0;
        end
        else
        begin
            for (int e = 0; e < E; e++)
            begin
                cnt[e] <= cnt[e] + OST_W'(inc[e]) - OST_W'(dec[e]);
                if (inc[e])
                begin
                    dst[e] <= req_dest;
                end
            end
        end
    end

    chk_cyclic_dependency_avoidance_mismatch: assert property (@(posedge clock) disable iff (sys_rst)
        (cnt[ri] != '0 && dst[ri] != req_dest) |-> !pass)
        else $error("mismatched destination passed");
    chk_cyclic_dependency_avoidance_free: assert property (@(posedge clock) disable iff (sys_rst)
        (cnt[ri] == '0) |-> pass) else $error("idle ID stalled");
endmodule // admission_guard

/* arb_if.sv */
// Request and grant bundle between an admission front end and one node.
// Assumes the node answers within the same cycle.
`timescale 1ns/10ps
interface arb_if
#(
    parameter int N = 4
);
    logic [N-1:0] req;
    logic [N-1:0][interconnect_admission_pkg::QOS_W-1:0] qos;
    logic [N-1:0] win;
    logic take;

    modport node (input req, input qos, input take, output win);
    modport user (output req, output qos, output take, input win);
endinterface

/* interconnect_admission_control.sv */
// Admission, ordering, lock and security filter for an interconnect.
// Index 0 of each channel pair is read, index 1 is write.
// Assumes a master holds its request until granted and drops it after.
`timescale 1ns/10ps
module interconnect_admission_control
#(
    parameter int N = 4,
    parameter int D = 4,
    parameter int IW = 2,
    parameter int DW = $clog2(D),
    parameter int SW = $clog2(N),
    parameter int GPV_DEST = D - 1,
    parameter logic [N-1:0][1:0] QOS_MODE = {N{interconnect_admission_pkg::QOS_MASTER}},
    parameter logic [interconnect_admission_pkg::QOS_W-1:0] QOS_STATIC = '0,
    parameter logic [N-1:0][1:0] SEC_MODE = {N{interconnect_admission_pkg::SEC_PASS}},
    parameter logic [N-1:0] CYCLIC_DEPENDENCY_AVOIDANCE_MODE = '0,
    parameter logic [N-1:0] LOCK_EN = '1,
    parameter logic [D-1:0][1:0] MI_SEC_MODE = {D{interconnect_admission_pkg::MI_BOOT_S}},
    parameter logic SAS_EN = 1'b1
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [1:0][N-1:0] addr_valid,
    input wire logic [1:0][N-1:0][IW-1:0] addr_id,
    input wire logic [1:0][N-1:0][DW-1:0] addr_dest,
    input wire logic [1:0][N-1:0][interconnect_admission_pkg::QOS_W-1:0] addr_qos,
    input wire logic [1:0][N-1:0] addr_ns,
    input wire logic [1:0][N-1:0] addr_lock,
    input wire logic [1:0][N-1:0] done,
    input wire logic [1:0][N-1:0][IW-1:0] done_id,
    input wire logic [N-1:0][interconnect_admission_pkg::QOS_W-1:0] qos_prog,
    input wire logic wdata_last,
    input wire logic sec_wr_en,
    input wire logic [DW-1:0] sec_wr_dest,
    input wire logic sec_wr_ns,
    output logic [1:0][N-1:0] grant,
    output logic [1:0][N-1:0] decerr,
    output logic locked,
    output logic [SW-1:0] lock_owner,
    output logic [D-1:0] mi_secure,
    output logic sec_pending
);
    import interconnect_admission_pkg::*;

    lock_state_e state;
    lock_state_e next_state;
    logic [1:0][N-1:0] ns_eff;
    logic [1:0][N-1:0] lock_eff;
    logic [1:0][N-1:0] bad;
    logic [1:0][N-1:0] pass;
    logic [1:0][N-1:0] allow;
    logic [1:0][N-1:0] busy;
    logic [1:0][N-1:0] win;
    logic [1:0][N-1:0][QOS_W-1:0] qos_eff;
    logic [1:0] take;
    logic [1:0] wlock;
    logic [1:0] wbad;
    logic [1:0] lockreq;
    logic [1:0][SW-1:0] wsrc;
    logic [1:0][DW-1:0] wdest;
    logic busy_any;
    logic sec_busy;
    logic [OST_W-1:0] wd_cnt;
    logic [DW-1:0] wd_dest;
    logic [DW-1:0] sec_dest;
    logic sec_ns;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // --------------------
    // Per source front end
    // --------------------
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        for (genvar s = 0; s < N; s++)
        begin : g_src
            assign ns_eff[c][s] = (SEC_MODE[s] == SEC_PASS) ? addr_ns[c][s] :
                (SEC_MODE[s] == SEC_FORCE_NS);
            assign qos_eff[c][s] = (QOS_MODE[s] == QOS_MASTER) ? addr_qos[c][s] :
                (QOS_MODE[s] == QOS_PROG) ? qos_prog[s] : QOS_STATIC;
            assign lock_eff[c][s] = addr_lock[c][s] & LOCK_EN[s];
            // Destination indexed check keeps each slave separate
            assign bad[c][s] = ns_eff[c][s] && (addr_dest[c][s] == DW'(GPV_DEST) ||
                mi_secure[addr_dest[c][s]]);
            assign allow[c][s] = addr_valid[c][s] && !grant[c][s] && !decerr[c][s] &&
                pass[c][s] &&
                (state == LK_IDLE || (state == LK_LOCKED && lock_owner == SW'(s))) &&
                (c == 0 || !SAS_EN || wd_cnt == '0 ||
                addr_dest[c][s] == wd_dest);

            // Separate tracker per channel, same scheme
            admission_guard #(.IW(IW), .DW(DW), .PER_ID(CYCLIC_DEPENDENCY_AVOIDANCE_MODE[s])) u_guard
            (
                .clock(clock),
                .sys_rst(sys_rst),
                .req_id(addr_id[c][s]),
                .req_dest(addr_dest[c][s]),
                .take(win[c][s] && take[c] && !bad[c][s]),
                .done(done[c][s]),
                .done_id(done_id[c][s]),
                .pass(pass[c][s]),
                .busy(busy[c][s])
            );
        end

        arb_if #(.N(N)) node_bus ();
        assign node_bus.req = allow[c];
        assign node_bus.qos = qos_eff[c];
        assign node_bus.take = take[c];
        assign win[c] = node_bus.win;

        qos_lru_arbiter #(.N(N)) u_arb
        (
            .clock(clock),
            .sys_rst(sys_rst),
            .port(node_bus.node)
        );
    end

    // --------------------
    // Winner attributes
    // --------------------
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            wlock[c] = 1'b0;
            wbad[c] = 1'b0;
            wsrc[c] = '0;
            wdest[c] = '0;
            for (int s = 0; s < N; s++)
            begin
                if (win[c][s])
                begin
                    wlock[c] = lock_eff[c][s];
                    wbad[c] = bad[c][s];
                    wsrc[c] = SW'(s);
                    wdest[c] = addr_dest[c][s];
                end
            end
        end
        lockreq = wlock & ~wbad;
        busy_any = |busy;
        sec_busy = busy_any || (state != LK_IDLE) || (|take);
    end

    // --------------------
    // Issue decision
    // --------------------
    always_comb
    begin
        case (state)
            LK_IDLE:
            begin
                // A locked winner is held; the other channel goes on unless locked too
                take[0] = (|win[0]) && !lockreq[0];
                take[1] = (|win[1]) && !lockreq[1];
            end
            LK_LOCKED: take = {|win[1], |win[0]};
            default: take = 2'b00;
        endcase
    end

    // --------------------
    // Lock sequencing
    // --------------------
    always_comb
    begin
        next_state = state;
        case (state)
            LK_IDLE:
            begin
                if (|lockreq)
                begin
                    next_state = LK_DRAIN;
                end
            end
            LK_DRAIN:
            begin
                if (!busy_any)
                begin
                    next_state = LK_LOCKED;
                end
            end
            LK_LOCKED:
            begin
                // Resized non-32-bit data may still lead the unlocking write
                if (|(take & ~wlock & ~wbad))
                begin
                    next_state = LK_RELEASE;
                end
            end
            LK_RELEASE:
            begin
                if (!busy_any)
                begin
                    next_state = LK_IDLE;
                end
            end
            default: next_state = LK_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= LK_IDLE;
            locked <= 1'b0;
            lock_owner <= '0;
        end
        else
        begin
            state <= next_state;
            locked <= (next_state != LK_IDLE);
            if (state == LK_IDLE && lockreq[0])
            begin
                lock_owner <= wsrc[0];
            end
            else if (state == LK_IDLE && lockreq[1])
            begin
                lock_owner <= wsrc[1];
            end
        end
    end

    // --------------------
    // Grant and error answers
    // --------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            grant <= '0;
            decerr <= '0;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                grant[c] <= win[c] & {N{take[c] && !wbad[c]}};
                decerr[c] <= win[c] & {N{take[c] && wbad[c]}};
            end
        end
    end

    // --------------------
    // Write data destination tracking
    // --------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wd_cnt <= '0;
            wd_dest <= '0;
        end
        else
        begin
            wd_cnt <= wd_cnt + OST_W'(take[1] && !wbad[1]) -
                OST_W'(wdata_last && wd_cnt != '0);
            if (take[1] && !wbad[1])
            begin
                wd_dest <= wdest[1];
            end
        end
    end

    // --------------------
    // Destination security settings
    // --------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int d = 0; d < D; d++)
            begin
                mi_secure[d] <= (MI_SEC_MODE[d] != MI_ALWAYS_NS);
            end
            sec_pending <= 1'b0;
            sec_dest <= '0;
            sec_ns <= 1'b0;
        end
        else if (sec_wr_en)
        begin
            sec_pending <= 1'b1;
            sec_dest <= sec_wr_dest;
            sec_ns <= sec_wr_ns;
        end
        else if (sec_pending && !sec_busy)
        begin
            sec_pending <= 1'b0;
            if (MI_SEC_MODE[sec_dest] == MI_BOOT_S)
            begin
                mi_secure[sec_dest] <= !sec_ns;
            end
        end
    end

    // --------------------
    // Checks
    // --------------------
    sequence both_lock_s;
        state == LK_IDLE && lockreq[0] && lockreq[1];
    endsequence

    sequence read_owns_s;
        state == LK_DRAIN && grant[1] == '0 && lock_owner == $past(wsrc[0]);
    endsequence

    sequence drained_s;
        state == LK_RELEASE && !busy_any;
    endsequence

    chk_read_lock_first: assert property (both_lock_s |=> read_owns_s)
        else $error("write lock not stalled behind read lock");
    chk_drain_blocks: assert property (state == LK_DRAIN |=> grant == '0 && decerr == '0)
        else $error("issue during lock drain");
    chk_locked_owner: assert property (state == LK_LOCKED |=>
        ((grant[0] | grant[1]) & ~(N'(1) << lock_owner)) == '0)
        else $error("non-owner granted while locked");
    chk_release_idle: assert property (drained_s |=> state == LK_IDLE && !locked)
        else $error("sources not re-enabled after unlock");
    chk_other_channel: assert property ((state == LK_IDLE && lockreq[1] && !lockreq[0] &&
        |win[0]) |=> (grant[0] | decerr[0]) != '0)
        else $error("coincident unlocked read held");
    chk_decerr_route: assert property ((take[1] && wbad[1]) |=>
        decerr[1] == $past(win[1]) && grant[1] == '0)
        else $error("non-secure write not refused");
    chk_sec_defer: assert property (sec_busy |=> $stable(mi_secure))
        else $error("security changed while busy");
    chk_sas_stall: assert property ((SAS_EN && wd_cnt != '0 && take[1] && !wbad[1]) |->
        wdest[1] == wd_dest) else $error("write address to second destination");
endmodule // interconnect_admission_control

/* interconnect_admission_pkg.sv */
// Shared constants and types for the interconnect admission block.
// Assumes one clock domain and masters that hold a request until granted.
// How it works
// - Each arbitration node grants the highest local QoS request first.
// - Equal QoS requests at one node are chosen least recently used.
// - Local QoS on entry is static, programmed, or taken from the master.
// - One avoidance scheme per ingress, reads and writes tracked apart.
// - Single-destination: a new destination waits until that type drains.
// - Per-ID scheme: an ID with nothing outstanding passes.
// - Per-ID scheme: a matching ID to the same destination passes.
// - Per-ID scheme: a matching ID to another destination stalls until passing.
// - Write address stalls while write data is owed to another destination.
// - A locked winner is held; a coincident unlocked other channel proceeds.
// - Lock entry blocks both channels, drains, then admits only the owner.
// - After the unlocking transaction completes, all sources arbitrate again.
// - Coincident lock requests on both channels: the read wins.
// - Lock order holds for 32-bit beats only; resized data may lead.
// - Security attribute per source: passed through, forced secure or non-secure.
// - Non-secure access to the programming view answers DECERR, no effect.
// - Non-secure access to a secure destination answers DECERR, not forwarded.
// - Non-secure destinations take both; boot-secure ones are software switchable.
// - Transactions in flight keep the security setting they were checked against.
// - A security update waits while transactions are pending or locked.
// - Each destination behind a shared port has its own security check.
// - Lock applies only to sources configured lock capable; others are unlocked.
package interconnect_admission_pkg;

    localparam int QOS_W = 4;
    localparam int OST_W = 6;

    localparam logic [1:0] QOS_STATIC_SEL = 2'h0;
    localparam logic [1:0] QOS_PROG = 2'h1;
    localparam logic [1:0] QOS_MASTER = 2'h2;

    localparam logic [1:0] SEC_PASS = 2'h0;
    localparam logic [1:0] SEC_FORCE_S = 2'h1;
    localparam logic [1:0] SEC_FORCE_NS = 2'h2;

    localparam logic [1:0] MI_ALWAYS_S = 2'h0;
    localparam logic [1:0] MI_ALWAYS_NS = 2'h1;
    localparam logic [1:0] MI_BOOT_S = 2'h2;

    localparam logic CYCLIC_DEPENDENCY_AVOIDANCE_SINGLE = 1'b0;
    localparam logic CYCLIC_DEPENDENCY_AVOIDANCE_PER_ID = 1'b1;

    typedef enum logic [1:0] {
        LK_IDLE = 2'h0,
        LK_DRAIN = 2'h1,
        LK_LOCKED = 2'h3,
        LK_RELEASE = 2'h2
    } lock_state_e;

endpackage

/* qos_lru_arbiter.sv */
// One arbitration node: QoS priority with least-recently-used ties.
// Assumes take is only raised together with a winner.
`timescale 1ns/10ps
module qos_lru_arbiter
#(
    parameter int N = 4
)
(
    input wire logic clock,
    input wire logic sys_rst,
    arb_if.node port
);
    import interconnect_admission_pkg::*;

    logic [N-1:0][N-1:0] older;
    logic outranked;

    // --------------------
    // Winner choice
    // --------------------
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            port.win[i] = port.req[i];
            for (int j = 0; j < N; j++)
            begin
                if (j != i && port.req[j] && !(port.qos[i] > port.qos[j] ||
                    (port.qos[i] == port.qos[j] && older[i][j])))
                begin
                    port.win[i] = 1'b0;
                end
            end
        end
    end

    // --------------------
    // Usage order
    // --------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < N; i++)
            begin
                for (int j = 0; j < N; j++)
                begin
                    older[i][j] <= (i < j);
                end
            end
        end
        else if (port.take)
        begin
            for (int g = 0; g < N; g++)
            begin
                if (port.win[g])
                begin
                    for (int j = 0; j < N; j++)
                    begin
                        if (j != g)
                        begin
                            older[g][j] <= 1'b0;
                            older[j][g] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_comb
    begin
        outranked = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            for (int j = 0; j < N; j++)
            begin
                if (port.win[i] && port.req[j] && port.qos[j] > port.qos[i])
                begin
                    outranked = 1'b1;
                end
            end
        end
    end

    chk_qos_highest_wins: assert property (@(posedge clock) disable iff (sys_rst)
        !outranked) else $error("lower QoS request granted");
    chk_single_winner: assert property (@(posedge clock) disable iff (sys_rst)
        |port.req |-> $onehot(port.win)) else $error("not exactly one winner");

    for (genvar k = 0; k < N; k++)
    begin : g_lru
        chk_lru_demote: assert property (@(posedge clock) disable iff (sys_rst)
            (port.take && port.win[k]) |=> older[k] == '0)
            else $error("granted source not demoted");
    end
endmodule // qos_lru_arbiter

/* slave_model.sv */
// Downstream slave model: completes admitted transactions in grant order.
// Assumes grant pulses one cycle and addr_id holds through that cycle.
`timescale 1ns/10ps
module slave_model
#(
    parameter int N = 4,
    parameter int IW = 2
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hold,
    input wire logic [1:0][N-1:0] grant,
    input wire logic [1:0][N-1:0][IW-1:0] addr_id,
    output logic [1:0][N-1:0] done,
    output logic [1:0][N-1:0][IW-1:0] done_id,
    output logic wdata_last
);
    // ----------------
    // Completion queue
    // ----------------
    int qc[$];
    int qs[$];
    logic [IW-1:0] qi[$];
    int c;
    int s;
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            qc.delete();
            qs.delete();
            qi.delete();
            done = '0;
            done_id = '0;
            wdata_last = 1'b0;
        end
        else
        begin
            for (int i = 0; i < 2 * N; i++)
                if (grant[i / N][i % N] === 1'b1)
                begin
                    qc.push_back(i / N);
                    qs.push_back(i % N);
                    qi.push_back(addr_id[i / N][i % N]);
                end
            #1;
            done = '0;
            done_id = ~done_id;
            wdata_last = 1'b0;
            if (!hold && qc.size() > 0)
            begin
                c = qc.pop_front();
                s = qs.pop_front();
                done[c][s] = 1'b1;
                done_id[c][s] = qi.pop_front();
                wdata_last = (c == 1);
            end
        end
    end
endmodule // slave_model

/* test_interconnect_admission_control.sv */
// Self-checking bench for the admission block.
// Assumes the slave model answers completions in grant order.
`timescale 1ns/10ps
module test_interconnect_admission_control;
    import interconnect_admission_pkg::*;
    localparam int N = 4;
    localparam int IW = 2;
    localparam int DW = 2;
    logic clock, sys_rst, hold, wdata_last, sec_wr_en, sec_wr_ns, locked, sec_pending;
    logic [1:0][N-1:0] addr_valid, addr_ns, addr_lock, done, grant, decerr;
    logic [1:0][N-1:0][IW-1:0] addr_id, done_id;
    logic [1:0][N-1:0][DW-1:0] addr_dest;
    logic [1:0][N-1:0][QOS_W-1:0] addr_qos;
    logic [N-1:0][QOS_W-1:0] qos_prog;
    logic [DW-1:0] sec_wr_dest;
    logic [1:0] lock_owner;
    logic [3:0] mi_secure;
    logic [31:0] seq;
    int mismatches, checked, cycles;

    interconnect_admission_control #(
        .QOS_MODE({QOS_MASTER, QOS_PROG, QOS_MASTER, QOS_MASTER}),
        .SEC_MODE({SEC_PASS, SEC_PASS, SEC_FORCE_S, SEC_PASS}),
        .CYCLIC_DEPENDENCY_AVOIDANCE_MODE(4'h8),
        .LOCK_EN(4'hD)
    ) u_dut (.clock(clock), .sys_rst(sys_rst), .addr_valid(addr_valid),
        .addr_id(addr_id), .addr_dest(addr_dest), .addr_qos(addr_qos), .addr_ns(addr_ns),
        .addr_lock(addr_lock), .done(done), .done_id(done_id), .qos_prog(qos_prog),
        .wdata_last(wdata_last), .sec_wr_en(sec_wr_en), .sec_wr_dest(sec_wr_dest),
        .sec_wr_ns(sec_wr_ns), .grant(grant), .decerr(decerr), .locked(locked),
        .lock_owner(lock_owner), .mi_secure(mi_secure), .sec_pending(sec_pending));

    slave_model u_slave (.clock(clock), .sys_rst(sys_rst), .hold(hold), .grant(grant),
        .addr_id(addr_id), .done(done), .done_id(done_id), .wdata_last(wdata_last));

    // -------
    // Helpers
    // -------
    task close_out;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] e, input logic [31:0] got);
        checked++;
        if (got !== e)
        begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, e, got);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task req(input int c, input int s, input int d, input int q, input int lk, input int ns,
        input int id);
        addr_dest[c][s] = DW'(d);
        addr_qos[c][s] = QOS_W'(q);
        addr_lock[c][s] = lk[0];
        addr_ns[c][s] = ns[0];
        addr_id[c][s] = IW'(id);
        addr_valid[c][s] = 1'b1;
    endtask

    // Result 1 = granted, 2 = refused, 0 = nothing within lim cycles
    task exp_g(input string what, input int c, input int s, input int lim, input int e);
        int r;
        r = 0;
        for (int i = 0; i < lim && r == 0; i++)
        begin
            step(1);
            if (grant[c][s] === 1'b1)
                r = 1;
            if (decerr[c][s] === 1'b1)
                r = r + 2;
        end
        if (r != 0)
        begin
            addr_valid[c][s] = 1'b0;
            step(1);
        end
        chk(what, e, r);
    endtask

    task order_of(input int c, input int n);
        seq = '0;
        repeat (8 * n)
        begin
            step(1);
            for (int s = 0; s < N; s++)
                if (grant[c][s] === 1'b1)
                begin
                    seq = (seq << 4) | 32'(s);
                    addr_valid[c][s] = 1'b0;
                end
        end
    endtask

    // ---------
    // Scenarios
    // ---------
    task t_reset;
        chk("grant", 0, grant);
        chk("locked", 0, locked);
        chk("mi_secure", 4'hF, mi_secure);
        chk("sec_pending", 0, sec_pending);
    endtask

    task t_qos;
        qos_prog[2] = 4'h3;
        req(0, 0, 0, 1, 0, 0, 0);
        req(0, 1, 0, 5, 0, 0, 0);
        req(0, 2, 0, 15, 0, 0, 0);
        req(0, 3, 0, 5, 0, 0, 0);
        order_of(0, 4);
        chk("qos order", 32'h1320, seq);
        req(0, 2, 0, 0, 0, 0, 0);
        req(0, 3, 0, 3, 0, 0, 0);
        order_of(0, 2);
        chk("lru order", 32'h32, seq);
    endtask

    task t_cyclic_dependency_avoidance;
        hold = 1'b1;
        req(0, 0, 1, 0, 0, 0, 0);
        exp_g("read d1", 0, 0, 10, 1);
        req(1, 0, 2, 0, 0, 0, 0);
        exp_g("write d2", 1, 0, 10, 1);
        req(0, 0, 2, 0, 0, 0, 0);
        exp_g("read d2 stall", 0, 0, 6, 0);
        hold = 1'b0;
        exp_g("read d2 late", 0, 0, 20, 1);
        step(8);
    endtask

    task t_sas;
        hold = 1'b1;
        req(1, 0, 0, 0, 0, 0, 0);
        exp_g("write s0", 1, 0, 10, 1);
        req(1, 1, 1, 0, 0, 0, 0);
        exp_g("write s1 stall", 1, 1, 6, 0);
        hold = 1'b0;
        exp_g("write s1 late", 1, 1, 20, 1);
        step(8);
    endtask

    task t_perid;
        hold = 1'b1;
        req(0, 3, 0, 0, 0, 0, 1);
        exp_g("id1 d0", 0, 3, 10, 1);
        req(0, 3, 1, 0, 0, 0, 2);
        exp_g("id2 d1", 0, 3, 10, 1);
        req(0, 3, 1, 0, 0, 0, 2);
        exp_g("id2 d1 again", 0, 3, 10, 1);
        req(0, 3, 2, 0, 0, 0, 1);
        exp_g("id1 d2 stall", 0, 3, 6, 0);
        hold = 1'b0;
        exp_g("id1 d2 late", 0, 3, 20, 1);
        step(8);
    endtask

    task t_lock;
        hold = 1'b1;
        req(0, 0, 0, 0, 0, 0, 0);
        exp_g("before lock", 0, 0, 10, 1);
        req(0, 2, 0, 0, 1, 0, 0);
        req(1, 3, 0, 0, 1, 0, 0);
        step(2);
        chk("locked", 1, locked);
        chk("owner read", 2, lock_owner);
        exp_g("write held", 1, 3, 6, 0);
        hold = 1'b0;
        exp_g("locked read", 0, 2, 20, 1);
        req(0, 2, 0, 0, 0, 0, 0);
        exp_g("unlock read", 0, 2, 20, 1);
        req(0, 0, 0, 0, 0, 0, 0);
        exp_g("other channel", 0, 0, 20, 1);
        exp_g("next lock", 1, 3, 40, 1);
        chk("owner write", 3, lock_owner);
        req(1, 3, 0, 0, 0, 0, 0);
        exp_g("unlock write", 1, 3, 20, 1);
        step(8);
        chk("unlocked", 0, locked);
        req(0, 1, 0, 0, 1, 0, 0);
        exp_g("lock off", 0, 1, 10, 1);
        chk("no lock", 0, locked);
    endtask

    task t_sec;
        req(0, 0, 3, 0, 0, 1, 0);
        exp_g("ns to view", 0, 0, 10, 2);
        req(0, 0, 1, 0, 0, 1, 0);
        exp_g("ns to secure", 0, 0, 10, 2);
        req(0, 1, 1, 0, 0, 1, 0);
        exp_g("forced secure", 0, 1, 10, 1);
        hold = 1'b1;
        req(0, 0, 1, 0, 0, 0, 0);
        exp_g("secure read", 0, 0, 10, 1);
        sec_wr_dest = 2'h1;
        sec_wr_ns = 1'b1;
        sec_wr_en = 1'b1;
        step(1);
        sec_wr_en = 1'b0;
        step(5);
        chk("pending", 1, sec_pending);
        chk("held setting", 4'hF, mi_secure);
        hold = 1'b0;
        step(8);
        chk("applied", 0, sec_pending);
        chk("new setting", 4'hD, mi_secure);
        req(0, 0, 1, 0, 0, 1, 0);
        exp_g("ns to non-secure", 0, 0, 10, 1);
    endtask

    // --------------
    // Clock and flow
    // --------------
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        {sys_rst, hold, sec_wr_en, sec_wr_ns, sec_wr_dest} = '0;
        {addr_valid, addr_ns, addr_lock, addr_id, addr_dest, addr_qos, qos_prog} = '0;
        sys_rst = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_qos();
        t_cyclic_dependency_avoidance();
        t_sas();
        t_perid();
        t_lock();
        t_sec();
        close_out();
    end
endmodule // test_interconnect_admission_control
